//--- common/bdr_pkg.sv
// Constants, field layouts and types of the backlight diagnostics readback bank
package bdr_pkg;

    // Register indices as printed; the byte address is four times the index
    localparam logic [7:0] IDX_STATE_MACHINE = 8'h14;
    localparam logic [7:0] IDX_INPUT_DUTY = 8'h16;
    localparam logic [7:0] IDX_OUTPUT_DUTY = 8'h18;
    localparam logic [7:0] IDX_SINK_CURRENT = 8'h1a;
    localparam logic [7:0] IDX_BOOST_VOLTAGE = 8'h1c;
    localparam logic [7:0] IDX_STRAP_DETECT = 8'h1e;
    localparam int unsigned BYTES_PER_WORD = 4;

    // Register width of every readback register, and reset value of all but the strap register, whose bit 11 reads one
    localparam int unsigned REG_W = 16;
    localparam logic [15:0] READBACK_RESET = 16'h0000;

    // Field widths
    localparam int unsigned STATE_W = 5;
    localparam int unsigned DUTY_W = 16;
    localparam int unsigned SINK_CODE_W = 12;
    localparam int unsigned BOOST_CODE_W = 11;
    localparam int unsigned STRAP_FIELD_W = 3;

    // Field positions in the strap detection register
    localparam int unsigned LED_FREQ_LSB = 12;
    localparam int unsigned STRAP_ONE_BIT = 11;
    localparam int unsigned STRING_LSB = 8;
    localparam int unsigned BOOST_FREQ_LSB = 3;
    localparam int unsigned DIMMING_LSB = 0;

    // Present state codes
    localparam logic [4:0] ST_DISABLED = 5'h00;
    localparam logic [4:0] ST_REGULATOR_STARTUP = 5'h01;
    localparam logic [4:0] ST_MEMORY_READ = 5'h02;
    localparam logic [4:0] ST_STANDBY = 5'h03;
    localparam logic [4:0] ST_BOOST_RAMP_FIRST = 5'h04;
    localparam logic [4:0] ST_BOOST_RAMP_LAST = 5'h0f;
    localparam logic [4:0] ST_NORMAL = 5'h10;
    localparam logic [4:0] ST_SHUTDOWN = 5'h11;
    localparam logic [4:0] ST_FAULT_RECOVERY = 5'h12;
    localparam logic [4:0] ST_ALL_STRINGS_FAILED = 5'h13;

    // Decoded strap tables
    localparam logic [14:0] LED_FREQ_HZ [8] = '{15'h0098, 15'h0131, 15'h0262, 15'h04c5,
                                                15'h0989, 15'h1313, 15'h2626, 15'h4c4b};
    localparam logic [11:0] BOOST_FREQ_KHZ [8] = '{12'h064, 12'h0c8, 12'h12f, 12'h190,
                                                   12'h1f4, 12'h71a, 12'h7d0, 12'h8ae};
    localparam logic [6:0] BUS_ADDR_LOW_SET = 7'h3b;
    localparam logic [6:0] BUS_ADDR_HIGH_SET = 7'h3a;
    localparam logic [2:0] STRINGS_FOUR = 3'h0;
    localparam logic [2:0] STRINGS_THREE = 3'h1;
    localparam logic [2:0] STRINGS_TWO = 3'h2;
    localparam logic [2:0] STRINGS_PAIRED = 3'h3;
    localparam logic [2:0] STRINGS_ONE = 3'h4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {
        DIM_PWM,
        DIM_HYBRID,
        DIM_CONSTANT_CURRENT,
        DIM_DIRECT_PWM
    } bdr_dimming_t;

endpackage : bdr_pkg

//--- src/bdr_strap_capture.sv
// Start-up capture of the four decoded strap codes
`timescale 1ns/1ns
module bdr_strap_capture
    import bdr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Decoded strap codes
    input wire logic [2:0] detected_led_frequency_in,
    input wire logic [2:0] detected_string_grouping_in,
    input wire logic [2:0] detected_boost_frequency_in,
    input wire logic [2:0] dimming_strap_in,
    // Held codes
    output logic captured_out,
    output logic [2:0] led_frequency_out,
    output logic [2:0] string_grouping_out,
    output logic [2:0] boost_frequency_out,
    output logic [2:0] dimming_strap_out
);

    typedef struct packed {
        logic captured;
        logic [2:0] led_freq;
        logic [2:0] strings;
        logic [2:0] boost_freq;
        logic [2:0] dimming;
    } bdr_strap_state_t;

    bdr_strap_state_t state_q;
    bdr_strap_state_t state_d;

    // Straps are taken at the first edge after reset release, then held
    always_comb begin
        state_d = state_q;
        if (!state_q.captured) begin
            state_d.captured = 1'b1;
            state_d.led_freq = detected_led_frequency_in;
            state_d.strings = detected_string_grouping_in;
            state_d.boost_freq = detected_boost_frequency_in;
            state_d.dimming = dimming_strap_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign captured_out = state_q.captured;
    assign led_frequency_out = state_q.led_freq;
    assign string_grouping_out = state_q.strings;
    assign boost_frequency_out = state_q.boost_freq;
    assign dimming_strap_out = state_q.dimming;

endmodule : bdr_strap_capture

//--- src/bdr_readback.sv
// Diagnostic readback register bank of the backlight driver, AXI4-Lite slave
//
// Contract
// R01: The present state of the functional state machine reads as a 5-bit code in bits 4 to 0.
// R02: The measured input duty cycle reads as a 16-bit read-only value.
// R03: The configured output duty cycle reads as a 16-bit read-only value.
// R04: The 12-bit sink current code reads in bits 11 to 0 with the upper four bits zero.
// R05: The 11-bit boost voltage code reads in bits 10 to 0 with the upper five bits zero.
// R06: The LED PWM frequency strap code reads in bits 14 to 12 and selects 152 to 19531 Hz.
// R07: The string grouping strap code reads in bits 10 to 8 and selects four to one strings.
// R08: The boost frequency strap code reads in bits 5 to 3 and selects 100 to 2222 kHz.
// R09: The dimming strap code reads in bits 2 to 0 and gives the mode and bus address.
// R10: Writes are ignored and reserved bits read zero, except strap register bit 11 reads one.
// R11: Every field follows its source so that each read returns the present value; the strap codes are held from start-up instead.
`timescale 1ns/1ns
module bdr_readback
    import bdr_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Live diagnostic sources
    input wire logic [STATE_W-1:0] present_state_code_in,
    input wire logic [DUTY_W-1:0] input_duty_in,
    input wire logic [DUTY_W-1:0] output_duty_in,
    input wire logic [SINK_CODE_W-1:0] sink_current_code_in,
    input wire logic [BOOST_CODE_W-1:0] boost_voltage_code_in,
    // Decoded strap codes
    input wire logic [2:0] detected_led_frequency_in,
    input wire logic [2:0] detected_string_grouping_in,
    input wire logic [2:0] detected_boost_frequency_in,
    input wire logic [2:0] dimming_strap_in,
    // Decoded configuration
    output logic straps_valid_out,
    output logic [1:0] dimming_mode_out,
    output logic [6:0] bus_address_out,
    output logic [14:0] led_pwm_freq_hz_out,
    output logic [11:0] boost_freq_khz_out,
    output logic [2:0] active_string_count_out,
    // Present state summary
    output logic boost_ramping_out,
    output logic normal_operation_out,
    output logic fault_state_out
);

    if (ADDR_W < 7 || ADDR_W > 32) begin : g_addr_check
        $error("bdr_readback: ADDR_W must lie between 7 and 32");
    end

    typedef enum logic [2:0] {
        SEL_STATE_MACHINE,
        SEL_INPUT_DUTY,
        SEL_OUTPUT_DUTY,
        SEL_SINK_CURRENT,
        SEL_BOOST_VOLTAGE,
        SEL_STRAP_DETECT,
        SEL_NONE
    } bdr_select_t;

    typedef struct packed {
        // Sampled sources
        logic [STATE_W-1:0] present_state;
        logic [DUTY_W-1:0] input_duty;
        logic [DUTY_W-1:0] output_duty;
        logic [SINK_CODE_W-1:0] sink_code;
        logic [BOOST_CODE_W-1:0] boost_code;
        // Write channel
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] aw_addr;
        logic bvalid;
        logic [1:0] bresp;
        // Read channel
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Decoded configuration and present state summary
        logic [1:0] dimming;
        logic [6:0] bus_addr;
        logic [14:0] led_hz;
        logic [11:0] boost_khz;
        logic [2:0] strings;
        logic boost_ramping;
        logic normal_op;
        logic fault_state;
    } bdr_state_t;

    bdr_state_t state_q;
    bdr_state_t state_d;

    logic straps_captured;
    logic [2:0] strap_led_freq;
    logic [2:0] strap_strings;
    logic [2:0] strap_boost_freq;
    logic [2:0] strap_dimming;
    logic aw_take;
    logic w_take;
    logic ar_take;

    bdr_strap_capture u_strap_capture (
        .sys_clk_in (sys_clk_in),
        .arst_n_in (arst_n_in),
        .detected_led_frequency_in (detected_led_frequency_in),
        .detected_string_grouping_in (detected_string_grouping_in),
        .detected_boost_frequency_in (detected_boost_frequency_in),
        .dimming_strap_in (dimming_strap_in),
        .captured_out (straps_captured),
        .led_frequency_out (strap_led_freq),
        .string_grouping_out (strap_strings),
        .boost_frequency_out (strap_boost_freq),
        .dimming_strap_out (strap_dimming)
    );

    // Maps a byte address onto one of the readback registers
    function automatic bdr_select_t decode_addr(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        bdr_select_t sel;
        word = addr >> 2;
        sel = SEL_NONE;
        if (addr[1:0] == 2'b00) begin
            if (word == ADDR_W'(IDX_STATE_MACHINE)) begin
                sel = SEL_STATE_MACHINE;
            end else if (word == ADDR_W'(IDX_INPUT_DUTY)) begin
                sel = SEL_INPUT_DUTY;
            end else if (word == ADDR_W'(IDX_OUTPUT_DUTY)) begin
                sel = SEL_OUTPUT_DUTY;
            end else if (word == ADDR_W'(IDX_SINK_CURRENT)) begin
                sel = SEL_SINK_CURRENT;
            end else if (word == ADDR_W'(IDX_BOOST_VOLTAGE)) begin
                sel = SEL_BOOST_VOLTAGE;
            end else if (word == ADDR_W'(IDX_STRAP_DETECT)) begin
                sel = SEL_STRAP_DETECT;
            end
        end
        return sel;
    endfunction : decode_addr

    // Packs the strap detection register
    function automatic logic [REG_W-1:0] strap_word(input logic [2:0] led_freq,
                                                     input logic [2:0] strings,
                                                     input logic [2:0] boost_freq,
                                                     input logic [2:0] dimming);
        logic [REG_W-1:0] w;
        w = READBACK_RESET;
        w[LED_FREQ_LSB +: STRAP_FIELD_W] = led_freq; // R06
        w[STRAP_ONE_BIT] = 1'b1; // R10
        w[STRING_LSB +: STRAP_FIELD_W] = strings; // R07
        w[BOOST_FREQ_LSB +: STRAP_FIELD_W] = boost_freq; // R08
        w[DIMMING_LSB +: STRAP_FIELD_W] = dimming; // R09
        return w;
    endfunction : strap_word

    // Number of driven strings for a grouping code, zero when the code is invalid
    function automatic logic [2:0] string_count(input logic [2:0] code);
        logic [2:0] n;
        case (code)
            STRINGS_FOUR: n = 3'h4;
            STRINGS_THREE: n = 3'h3;
            STRINGS_TWO: n = 3'h2;
            STRINGS_PAIRED: n = 3'h2;
            STRINGS_ONE: n = 3'h1;
            default: n = 3'h0;
        endcase
        return n;
    endfunction : string_count

    // Assembles the read word; reserved upper bits stay zero
    function automatic logic [31:0] read_word(input bdr_select_t sel,
                                              input bdr_state_t s,
                                              input logic [REG_W-1:0] straps);
        logic [31:0] w;
        w = '0;
        case (sel)
            SEL_STATE_MACHINE: w[STATE_W-1:0] = s.present_state; // R01
            SEL_INPUT_DUTY: w[DUTY_W-1:0] = s.input_duty; // R02
            SEL_OUTPUT_DUTY: w[DUTY_W-1:0] = s.output_duty; // R03
            SEL_SINK_CURRENT: w[SINK_CODE_W-1:0] = s.sink_code; // R04
            SEL_BOOST_VOLTAGE: w[BOOST_CODE_W-1:0] = s.boost_code; // R05
            SEL_STRAP_DETECT: w[REG_W-1:0] = straps;
            default: w = '0;
        endcase
        return w;
    endfunction : read_word

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] wr_addr;
        bdr_select_t rd_sel;
        aw_have = 1'b0;
        w_have = 1'b0;
        wr_addr = '0;
        rd_sel = SEL_NONE;
        state_d = state_q;

        // Sources are resampled every cycle
        state_d.present_state = present_state_code_in; // R11
        state_d.input_duty = input_duty_in; // R11
        state_d.output_duty = output_duty_in; // R11
        state_d.sink_code = sink_current_code_in; // R11
        state_d.boost_code = boost_voltage_code_in; // R11

        // Write path: address and data in either order, then one response
        if (s_axi_bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end
        if (aw_take) begin
            state_d.aw_addr = s_axi_awaddr;
        end
        aw_have = state_q.aw_held || aw_take;
        w_have = state_q.w_held || w_take;
        wr_addr = aw_take ? s_axi_awaddr : state_q.aw_addr;
        if (aw_have && w_have) begin
            state_d.aw_held = 1'b0;
            state_d.w_held = 1'b0;
            state_d.bvalid = 1'b1;
            // Data are dropped; only the answer depends on the address
            if (decode_addr(wr_addr) == SEL_NONE) begin // R10
                state_d.bresp = RESP_DECERR;
            end else begin
                state_d.bresp = RESP_OKAY;
            end
        end else begin
            state_d.aw_held = aw_have;
            state_d.w_held = w_have;
        end

        // Read path: the word is captured at the address handshake
        if (s_axi_rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            rd_sel = decode_addr(s_axi_araddr);
            state_d.rvalid = 1'b1;
            state_d.rdata = read_word(rd_sel, state_q,
                                      strap_word(strap_led_freq, strap_strings,
                                                 strap_boost_freq, strap_dimming));
            state_d.rresp = (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end

        // Decoded strap settings
        state_d.led_hz = LED_FREQ_HZ[strap_led_freq]; // R06
        state_d.strings = string_count(strap_strings); // R07
        state_d.boost_khz = BOOST_FREQ_KHZ[strap_boost_freq]; // R08
        state_d.dimming = strap_dimming[1:0]; // R09
        state_d.bus_addr = strap_dimming[2] ? BUS_ADDR_HIGH_SET : BUS_ADDR_LOW_SET; // R09

        // Present state summary
        state_d.boost_ramping = (present_state_code_in >= ST_BOOST_RAMP_FIRST) &&
                                (present_state_code_in <= ST_BOOST_RAMP_LAST); // R01
        state_d.normal_op = (present_state_code_in == ST_NORMAL); // R01
        state_d.fault_state = (present_state_code_in == ST_FAULT_RECOVERY) ||
                              (present_state_code_in == ST_ALL_STRINGS_FAILED); // R01
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Handshake outputs; one transfer of each kind at a time
    assign s_axi_awready = !state_q.aw_held && !state_q.bvalid;
    assign s_axi_wready = !state_q.w_held && !state_q.bvalid;
    assign s_axi_arready = !state_q.rvalid;

    assign s_axi_bvalid = state_q.bvalid;
    assign s_axi_bresp = state_q.bresp;
    assign s_axi_rvalid = state_q.rvalid;
    assign s_axi_rdata = state_q.rdata;
    assign s_axi_rresp = state_q.rresp;

    assign straps_valid_out = straps_captured;
    assign dimming_mode_out = state_q.dimming;
    assign bus_address_out = state_q.bus_addr;
    assign led_pwm_freq_hz_out = state_q.led_hz;
    assign boost_freq_khz_out = state_q.boost_khz;
    assign active_string_count_out = state_q.strings;
    assign boost_ramping_out = state_q.boost_ramping;
    assign normal_operation_out = state_q.normal_op;
    assign fault_state_out = state_q.fault_state;

endmodule : bdr_readback

//--- testbench/bdr_readback_checker.sv
// Bus timing and readback field checks for the diagnostics bank
`timescale 1ns/1ns
module bdr_readback_checker
    import bdr_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Straps
    input wire logic [2:0] dimming_strap_in,
    input wire logic straps_valid_out,
    input wire logic [6:0] bus_address_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // Address of the read now being answered
    logic [ADDR_W-1:0] rd_addr_q;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_addr_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end

    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    chk_state_reserved: assert property (s_axi_rvalid && rd_addr_q[7:0] == 8'h50
        |-> s_axi_rdata[31:5] == 27'h0) else $error("state word upper bits set");
    chk_duty_upper: assert property (s_axi_rvalid && (rd_addr_q[7:0] == 8'h58
        || rd_addr_q[7:0] == 8'h60) |-> s_axi_rdata[31:16] == 16'h0) else $error("duty wide");
    chk_sink_reserved: assert property (s_axi_rvalid && rd_addr_q[7:0] == 8'h68
        |-> s_axi_rdata[31:12] == 20'h0) else $error("sink word upper bits set");
    chk_boost_reserved: assert property (s_axi_rvalid && rd_addr_q[7:0] == 8'h70
        |-> s_axi_rdata[31:11] == 21'h0) else $error("boost word upper bits set");
    chk_strap_fixed: assert property (s_axi_rvalid && rd_addr_q[7:0] == 8'h78
        |-> s_axi_rdata[31:15] == 17'h0 && s_axi_rdata[11] && s_axi_rdata[7:6] == 2'h0)
        else $error("strap word fixed bits wrong");
    chk_unaligned_err: assert property (s_axi_rvalid && rd_addr_q[1:0] != 2'h0
        |-> s_axi_rresp == RESP_DECERR) else $error("unaligned read accepted");
    chk_bus_address: assert property (straps_valid_out && $past(straps_valid_out)
        |-> bus_address_out == (dimming_strap_in[2] ? BUS_ADDR_HIGH_SET : BUS_ADDR_LOW_SET))
        else $error("bus address decode wrong");

    cov_strap_read: cover property (s_axi_rvalid && rd_addr_q[7:0] == 8'h78);
    cov_read_stall: cover property (s_axi_rvalid && !s_axi_rready ##1 s_axi_rready);
    cov_write_done: cover property (s_axi_bvalid);
endmodule : bdr_readback_checker

bind bdr_readback bdr_readback_checker #(.ADDR_W(ADDR_W)) i_bdr_readback_checker (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .dimming_strap_in(dimming_strap_in),
    .straps_valid_out(straps_valid_out),
    .bus_address_out(bus_address_out)
);

//--- testbench/tb.sv
// Self-checking bench for the diagnostics readback bank
`timescale 1ns/1ns
module tb
    import bdr_pkg::*;
;
    logic sys_clk_in, arst_n_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, dimming_mode_out;
    logic [4:0] present_state_code_in;
    logic [15:0] input_duty_in, output_duty_in;
    logic [11:0] sink_current_code_in, boost_freq_khz_out;
    logic [10:0] boost_voltage_code_in;
    logic [2:0] detected_led_frequency_in, detected_string_grouping_in;
    logic [2:0] detected_boost_frequency_in, dimming_strap_in, active_string_count_out;
    logic straps_valid_out, boost_ramping_out, normal_operation_out, fault_state_out;
    logic [6:0] bus_address_out;
    logic [14:0] led_pwm_freq_hz_out;
    logic [7:0] map [5] = '{8'h50, 8'h58, 8'h60, 8'h68, 8'h70};
    logic [31:0] exp_v [5] = '{32'h13, 32'hffff, 32'h8001, 32'hfff, 32'h7ff};
    logic [2:0] cnt [5] = '{3'h4, 3'h3, 3'h2, 3'h2, 3'h1};
    int failures, compares, cycles, stall;

    bdr_readback i_bdr_readback (.sys_clk_in, .arst_n_in, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .present_state_code_in, .input_duty_in, .output_duty_in, .sink_current_code_in,
        .boost_voltage_code_in, .detected_led_frequency_in, .detected_string_grouping_in,
        .detected_boost_frequency_in, .dimming_strap_in, .straps_valid_out, .dimming_mode_out,
        .bus_address_out, .led_pwm_freq_hz_out, .boost_freq_khz_out, .active_string_count_out,
        .boost_ramping_out, .normal_operation_out, .fault_state_out);

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report;
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_resp

    task automatic axi_read(input logic [7:0] a);
        logic hs;
        @(posedge sys_clk_in);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= (stall == 0);
        do begin
            @(negedge sys_clk_in);
            hs = s_axi_arready;
            @(posedge sys_clk_in);
        end while (!hs);
        s_axi_arvalid <= 1'b0;
        repeat (stall) @(posedge sys_clk_in);
        s_axi_rready <= 1'b1;
        do begin
            @(negedge sys_clk_in);
            hs = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge sys_clk_in);
        end while (!hs);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, ad, wd;
        @(posedge sys_clk_in);
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge sys_clk_in);
            ah = s_axi_awready && !ad;
            wh = s_axi_wready && !wd;
            @(posedge sys_clk_in);
            if (ah) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (wh) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(negedge sys_clk_in);
            ah = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge sys_clk_in);
        end while (!ah);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check_word(rd, exp);
        check_resp(rr, RESP_OKAY);
    endtask : rd_chk

    // Straps change only while reset is held, as at power-up
    task automatic do_reset(input logic [2:0] c);
        @(posedge sys_clk_in);
        arst_n_in <= 1'b0;
        detected_led_frequency_in <= c;
        detected_string_grouping_in <= 3'(c % 5);
        detected_boost_frequency_in <= ~c;
        dimming_strap_in <= c;
        repeat (4) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
    endtask : do_reset

    initial begin
        arst_n_in = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {present_state_code_in, input_duty_in, output_duty_in} = 37'h0;
        {sink_current_code_in, boost_voltage_code_in} = 23'h0;
        stall = 0;
        do_reset(3'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk(map[i], 32'h0);
        end
        for (int i = 0; i < 20; i++) begin
            present_state_code_in <= 5'(i);
            rd_chk(8'h50, 32'(i));
            check_word(32'({boost_ramping_out, normal_operation_out, fault_state_out}),
                32'({i > 3 && i < 16, i == 16, i > 17}));
        end
        input_duty_in <= 16'hffff;
        output_duty_in <= 16'h8001;
        sink_current_code_in <= 12'hfff;
        boost_voltage_code_in <= 11'h7ff;
        for (int i = 0; i < 5; i++) begin
            axi_write(map[i], 32'hffff_ffff);
            check_resp(rr, RESP_OKAY);
            rd_chk(map[i], exp_v[i]);
        end
        axi_write(8'h7c, 32'h0);
        check_resp(rr, RESP_DECERR);
        axi_read(8'h54);
        check_resp(rr, RESP_DECERR);
        axi_read(8'h51);
        check_resp(rr, RESP_DECERR);
        stall = 3;
        input_duty_in <= 16'h1234;
        rd_chk(8'h58, 32'h1234);
        input_duty_in <= 16'h4321;
        rd_chk(8'h58, 32'h4321);
        stall = 0;
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c));
            axi_write(8'h78, 32'h0);
            rd_chk(8'h78, {17'h0, 3'(c), 1'b1, 3'(c % 5), 2'h0, ~3'(c), 3'(c)});
            check_word(32'(led_pwm_freq_hz_out), 32'(LED_FREQ_HZ[c]));
            check_word(32'(boost_freq_khz_out), 32'(BOOST_FREQ_KHZ[7 - c]));
            check_word(32'(bus_address_out), (c > 3) ? 32'h3a : 32'h3b);
            check_word(32'({straps_valid_out, dimming_mode_out, active_string_count_out}),
                {26'h0, 1'b1, 2'(c), cnt[c % 5]});
        end
        final_report;
    end
endmodule : tb
